/* File: rtl/dps_pkg.sv */
// Shared constants for the drive panel and startup self-test block
package dps_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned BASIC_TEST_MS = 3000;
	localparam int unsigned EXT_TEST_MS = 10000;
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned RESUME_BLINK_MS = 500;
	localparam int unsigned BASIC_TEST_CYC = (CLK_HZ / 1000) * BASIC_TEST_MS;
	localparam int unsigned EXT_STEP_CYC = ((CLK_HZ / 1000) * EXT_TEST_MS) / 7;
	localparam int unsigned BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
	localparam int unsigned RESUME_BLINK_CYC = (CLK_HZ / 1000) * RESUME_BLINK_MS;
	localparam int unsigned SER_HALF_CYC = 8;
	// Diagnostic port codes
	localparam logic [7:0] CODE_OK = 8'h00;
	localparam logic [7:0] CODE_ROM = 8'h01;
	localparam logic [7:0] CODE_RAM = 8'h02;
	localparam logic [7:0] CODE_BUF = 8'h03;
	// Completion status field position for execution error
	localparam int unsigned STAT_EXEC_ERR_BIT = 1;
	localparam logic [7:0] STAT_RESET = 8'h00;
	// Format code selections
	localparam logic [1:0] FMT_10_0 = 2'h0;
	localparam logic [1:0] FMT_10_5 = 2'h1;
	// Extended test step count and the result code base for each step
	localparam int unsigned EXT_STEPS = 7;
	localparam logic [7:0] EXT_CODE_BASE = 8'h10;
endpackage : dps_pkg

/* File: rtl/dps_serial_tx.sv */
// Serial diagnostic code shifter: MSB first, data changes on clock fall
`timescale 1ns/1ps
module dps_serial_tx
	import dps_pkg::*;
#(
	parameter int unsigned HALF_CYC = SER_HALF_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic send_in,
	input wire logic [7:0] code_in,
	output logic busy_out,
	output logic diag_clk_out,
	output logic diag_data_out
);
	logic [7:0] shift_r;
	logic [3:0] bits_left_r;
	logic [15:0] half_cnt_r;
	logic active_r;

	// Shift engine; data is set while the clock is low, rising edge is the sample point
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			shift_r <= 8'h00;
			bits_left_r <= 4'h0;
			half_cnt_r <= 16'h0000;
			active_r <= 1'b0;
			diag_clk_out <= 1'b0;
			diag_data_out <= 1'b0;
		end else if (!active_r) begin
			diag_clk_out <= 1'b0;
			if (send_in) begin
				active_r <= 1'b1;
				diag_data_out <= code_in[7];
				shift_r <= {code_in[6:0], 1'b0};
				bits_left_r <= 4'h8;
				half_cnt_r <= 16'h0000;
			end
		end else if (half_cnt_r == 16'(HALF_CYC - 1)) begin
			half_cnt_r <= 16'h0000;
			if (!diag_clk_out) begin
				diag_clk_out <= 1'b1; // Rising edge: display latches here
			end else begin
				// Falling edge: present next bit, or finish after the eighth
				diag_clk_out <= 1'b0;
				bits_left_r <= bits_left_r - 4'h1;
				if (bits_left_r == 4'h1) begin
					active_r <= 1'b0;
					diag_data_out <= 1'b0;
				end else begin
					diag_data_out <= shift_r[7];
					shift_r <= {shift_r[6:0], 1'b0};
				end
			end
		end else begin
			half_cnt_r <= half_cnt_r + 16'h0001;
		end
	end

	assign busy_out = active_r;
endmodule : dps_serial_tx

/* File: rtl/dps_panel.sv */
// Operator panel, spindle control, startup self-test and option latch
`timescale 1ns/1ps
// Notes on behaviour
// - Stop waits for current command, then spindle off
// - Latch held until motor fully stopped
// - Seated switch means loaded; latch engages
// - Ready blinks during spin-up, steady at speed
// - Dwell timeout halves speed; brief blink returning
// - Stop blinks ready during spin-down, off at release
// - Activity lit exactly while servicing command
// - Power-up checks RAM, ROM, buffer, about 3s
// - Basic failure blocks selection, codes 01/02/03
// - Extended tests after basic, switch or host
// - Seven extended tests in fixed order
// - Extended failure: display code, abort next command
// - Later commands accepted normally after abort
// - Parity switch off enables parity checking
// - Two-switch field decodes retries and diagnostics
// - Capacity switch picks 10.0 or 10.5 code
// - Option switches latched only after reset
// - Error code shifted out eight bits with clock
// - One shunt; respond when its line asserted
// - Code 00 means normal completion
module dps_panel
	import dps_pkg::*;
#(
	parameter int unsigned BASIC_CYC = BASIC_TEST_CYC,
	parameter int unsigned EXT_CYC = EXT_STEP_CYC,
	parameter int unsigned BLINK_HALF_CYC = BLINK_CYC,
	parameter int unsigned RESUME_CYC = RESUME_BLINK_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic stop_button_in,
	input wire logic motor_seated_in,
	input wire logic motor_at_speed_in,
	input wire logic motor_stopped_in,
	input wire logic dwell_timeout_in,
	input wire logic cmd_active_in,
	input wire logic cmd_start_in,
	input wire logic host_diag_req_in,
	input wire logic rom_fail_in,
	input wire logic ram_fail_in,
	input wire logic buf_fail_in,
	input wire logic [6:0] ext_fail_in,
	input wire logic manual_reset_switch_in,
	input wire logic parity_option_switch_in,
	input wire logic diag_enable_switch_in,
	input wire logic retry_option_switch_in,
	input wire logic capacity_code_switch_in,
	input wire logic [7:0] bus_address_shunt_in,
	input wire logic [7:0] bus_data_in,
	input wire logic bus_sel_in,
	output logic spindle_on_out,
	output logic half_speed_out,
	output logic latch_engage_out,
	output logic ready_led_out,
	output logic activity_led_out,
	output logic self_test_done_out,
	output logic select_resp_out,
	output logic cmd_abort_out,
	output logic [7:0] cmd_status_out,
	output logic [2:0] ext_test_step_out,
	output logic parity_check_en_out,
	output logic retries_en_out,
	output logic startup_diag_en_out,
	output logic repeat_diag_out,
	output logic [1:0] format_code_out,
	output logic diag_clk_out,
	output logic diag_data_out
);
	typedef enum logic [5:0] {
		SP_IDLE = 6'b000001,
		SP_SPINUP = 6'b000010,
		SP_FULL = 6'b000100,
		SP_HALF = 6'b001000,
		SP_STOPREQ = 6'b010000,
		SP_SPINDOWN = 6'b100000
	} dps_spin_t;

	typedef enum logic [4:0] {
		ST_BASIC = 5'b00001,
		ST_EXT = 5'b00010,
		ST_RUN = 5'b00100,
		ST_FAIL = 5'b01000,
		ST_LATCH = 5'b10000
	} dps_test_t;

	// Two-flop synchronisers for the 13 stop, motor, switch and basic-test inputs
	localparam int unsigned NSYNC = 13;
	logic [NSYNC-1:0] sync_a_r;
	logic [NSYNC-1:0] sync_b_r;
	logic stop_s, seated_s, speed_s, stopped_s, dwell_s, mrst_s;
	logic par_s, diag_s, retry_s, cap_s, rom_s, ram_s, buf_s;
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sync_a_r <= '0;
			sync_b_r <= '0;
		end else begin
			sync_a_r <= {stop_button_in, motor_seated_in, motor_at_speed_in, motor_stopped_in, dwell_timeout_in,
				manual_reset_switch_in, parity_option_switch_in, diag_enable_switch_in, retry_option_switch_in,
				capacity_code_switch_in, rom_fail_in, ram_fail_in, buf_fail_in};
			sync_b_r <= sync_a_r;
		end
	end
	assign {stop_s, seated_s, speed_s, stopped_s, dwell_s, mrst_s, par_s, diag_s, retry_s, cap_s,
		rom_s, ram_s, buf_s} = sync_b_r;

	// Manual reset switch on holds everything but the synchronisers in reset
	logic run_rst_n;
	assign run_rst_n = rst_n_in & ~mrst_s;

	// Option latch: captured once, a few cycles after release so synchronisers are valid
	logic [1:0] opt_wait_r;
	logic opt_taken_r;
	always_ff @(posedge ref_clk_in) begin
		if (!run_rst_n) begin
			opt_wait_r <= 2'h0;
			opt_taken_r <= 1'b0;
			parity_check_en_out <= 1'b0;
			retries_en_out <= 1'b0;
			startup_diag_en_out <= 1'b0;
			repeat_diag_out <= 1'b0;
			format_code_out <= FMT_10_0;
		end else if (!opt_taken_r) begin
			opt_wait_r <= opt_wait_r + 2'h1;
			if (opt_wait_r == 2'h3) begin
				opt_taken_r <= 1'b1;
				parity_check_en_out <= ~par_s;
				retries_en_out <= ~retry_s | diag_s;
				startup_diag_en_out <= diag_s;
				repeat_diag_out <= diag_s & retry_s;
				format_code_out <= cap_s ? FMT_10_5 : FMT_10_0;
			end
		end
	end

	// Startup test sequencer
	dps_test_t test_r;
	logic [31:0] test_cnt_r;
	logic [2:0] step_r;
	logic [7:0] err_code_r;
	logic err_send_r;
	logic abort_pend_r;
	always_ff @(posedge ref_clk_in) begin
		if (!run_rst_n) begin
			test_r <= ST_LATCH;
			test_cnt_r <= 32'h0000_0000;
			step_r <= 3'h0;
			err_code_r <= CODE_OK;
			err_send_r <= 1'b0;
			abort_pend_r <= 1'b0;
		end else begin
			err_send_r <= 1'b0;
			if (cmd_start_in && abort_pend_r)
				abort_pend_r <= 1'b0;
			unique case (test_r)
				ST_LATCH: if (opt_taken_r) test_r <= ST_BASIC;
				ST_BASIC: begin
					test_cnt_r <= test_cnt_r + 32'h0000_0001;
					if (rom_s || ram_s || buf_s) begin
						// ROM CRC takes precedence, then RAM, then buffer
						err_code_r <= rom_s ? CODE_ROM : (ram_s ? CODE_RAM : CODE_BUF);
						err_send_r <= 1'b1;
						test_r <= ST_FAIL;
					end else if (test_cnt_r == 32'(BASIC_CYC - 1)) begin
						test_cnt_r <= 32'h0000_0000;
						step_r <= 3'h0;
						err_code_r <= CODE_OK;
						test_r <= startup_diag_en_out ? ST_EXT : ST_RUN;
					end
				end
				ST_EXT: begin
					test_cnt_r <= test_cnt_r + 32'h0000_0001;
					if (test_cnt_r == 32'(EXT_CYC - 1)) begin
						test_cnt_r <= 32'h0000_0000;
						if (ext_fail_in[step_r]) begin
							err_code_r <= EXT_CODE_BASE + 8'(step_r);
							err_send_r <= 1'b1;
							abort_pend_r <= 1'b1;
						end
						if (step_r == 3'(EXT_STEPS - 1)) begin
							step_r <= 3'h0;
							// Repeat mode loops back to the basic tests until a basic test fails
							test_r <= repeat_diag_out ? ST_BASIC : ST_RUN;
						end else begin
							step_r <= step_r + 3'h1;
						end
					end
				end
				ST_RUN: if (host_diag_req_in) begin
					test_cnt_r <= 32'h0000_0000;
					step_r <= 3'h0;
					test_r <= ST_EXT;
				end
				ST_FAIL: test_r <= ST_FAIL;
				default: test_r <= ST_FAIL;
			endcase
		end
	end
	assign self_test_done_out = (test_r == ST_RUN);
	assign ext_test_step_out = step_r;

	// Completion status and abort for the first command after an extended failure
	always_ff @(posedge ref_clk_in) begin
		if (!run_rst_n) begin
			cmd_abort_out <= 1'b0;
			cmd_status_out <= STAT_RESET;
		end else begin
			cmd_abort_out <= cmd_start_in & abort_pend_r;
			if (cmd_start_in)
				cmd_status_out <= abort_pend_r ? 8'(1 << STAT_EXEC_ERR_BIT) : STAT_RESET;
		end
	end

	// Selection: only when running or in the extended tests and our shunt's data line is high
	always_ff @(posedge ref_clk_in) begin
		if (!run_rst_n)
			select_resp_out <= 1'b0;
		else
			select_resp_out <= bus_sel_in && (test_r == ST_RUN || test_r == ST_EXT)
				&& ((bus_data_in & bus_address_shunt_in) != 8'h00);
	end

	// Spindle state machine
	dps_spin_t spin_r;
	logic resume_r;
	logic [31:0] resume_cnt_r;
	always_ff @(posedge ref_clk_in) begin
		if (!run_rst_n) begin
			spin_r <= SP_IDLE;
			resume_r <= 1'b0;
			resume_cnt_r <= 32'h0000_0000;
		end else begin
			if (resume_r) begin
				resume_cnt_r <= resume_cnt_r + 32'h0000_0001;
				if (resume_cnt_r == 32'(RESUME_CYC - 1))
					resume_r <= 1'b0;
			end
			unique case (spin_r)
				SP_IDLE: if (seated_s && !stop_s) spin_r <= SP_SPINUP;
				SP_SPINUP: begin
					if (stop_s) spin_r <= SP_STOPREQ;
					else if (speed_s) spin_r <= SP_FULL;
				end
				SP_FULL: begin
					if (stop_s) spin_r <= SP_STOPREQ;
					else if (dwell_s) spin_r <= SP_HALF;
				end
				SP_HALF: begin
					if (stop_s) begin
						spin_r <= SP_STOPREQ;
					end else if (cmd_start_in) begin
						// Back to full speed with a short blink
						spin_r <= SP_FULL;
						resume_r <= 1'b1;
						resume_cnt_r <= 32'h0000_0000;
					end
				end
				SP_STOPREQ: if (!cmd_active_in) spin_r <= SP_SPINDOWN;
				SP_SPINDOWN: if (stopped_s) spin_r <= SP_IDLE;
				default: spin_r <= SP_IDLE;
			endcase
		end
	end

	// Blink timebase
	logic [31:0] blink_cnt_r;
	logic blink_r;
	always_ff @(posedge ref_clk_in) begin
		if (!run_rst_n) begin
			blink_cnt_r <= 32'h0000_0000;
			blink_r <= 1'b0;
		end else if (blink_cnt_r == 32'(BLINK_HALF_CYC - 1)) begin
			blink_cnt_r <= 32'h0000_0000;
			blink_r <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
		end
	end

	// Panel outputs; spindle is kept on through a pending stop so the command finishes
	always_comb begin
		spindle_on_out = (spin_r != SP_IDLE) && (spin_r != SP_SPINDOWN);
		half_speed_out = (spin_r == SP_HALF);
		latch_engage_out = (spin_r != SP_IDLE);
		activity_led_out = cmd_active_in;
		unique case (spin_r)
			SP_SPINUP: ready_led_out = blink_r;
			SP_FULL: ready_led_out = resume_r ? blink_r : 1'b1;
			SP_HALF: ready_led_out = 1'b1;
			SP_STOPREQ, SP_SPINDOWN: ready_led_out = blink_r;
			default: ready_led_out = 1'b0;
		endcase
	end

	dps_serial_tx u_tx (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(run_rst_n),
		.send_in(err_send_r),
		.code_in(err_code_r),
		.busy_out(),
		.diag_clk_out(diag_clk_out),
		.diag_data_out(diag_data_out)
	);
endmodule : dps_panel

/* File: verification/dps_panel_monitor.sv */
// Port assertions for the drive panel and self-test block
`timescale 1ns/1ps
module dps_panel_monitor (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic cmd_active_in,
	input wire logic cmd_start_in,
	input wire logic [7:0] bus_address_shunt_in,
	input wire logic [7:0] bus_data_in,
	input wire logic bus_sel_in,
	input wire logic spindle_on_out,
	input wire logic latch_engage_out,
	input wire logic ready_led_out,
	input wire logic select_resp_out,
	input wire logic cmd_abort_out,
	input wire logic [7:0] cmd_status_out,
	input wire logic diag_clk_out,
	input wire logic diag_data_out
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Spindle, lever latch and lamp interlocks
	spin_latch_a: assert property (spindle_on_out |-> latch_engage_out) else $error("spin unlatched");
	free_stop_a: assert property ($fell(latch_engage_out) |-> !spindle_on_out) else $error("early release");
	stop_wait_a: assert property ($fell(spindle_on_out) |-> !$past(cmd_active_in)) else $error("stop mid cmd");
	dark_free_a: assert property (!latch_engage_out |-> !ready_led_out) else $error("ready lit");
	// Selection and abort answers
	sel_cause_a: assert property (select_resp_out |-> $past(bus_sel_in) &&
		($past(bus_data_in) & $past(bus_address_shunt_in)) != 8'h00) else $error("bad select");
	abort_stat_a: assert property (cmd_abort_out |-> $past(cmd_start_in) && cmd_status_out == 8'h02
		##1 !cmd_abort_out) else $error("bad abort");
	// Serial port: data moves only while the clock is low, high phase is 8 cycles
	ser_edge_a: assert property ($changed(diag_data_out) |-> !diag_clk_out) else $error("data moved");
	ser_high_a: assert property ($rose(diag_clk_out) |=> diag_clk_out [*7] ##1 !diag_clk_out) else $error("clk");
	// Main scenarios reached
	cov_abort: cover property (cmd_abort_out);
	cov_sel: cover property (select_resp_out);
	cov_ser: cover property ($rose(diag_clk_out));
endmodule : dps_panel_monitor

/* File: verification/dps_far_model.sv */
// Far side: spindle motor inertia and serial code display
`timescale 1ns/1ps
module dps_far_model #(
	parameter int unsigned SPIN_CYC = 40
) (
	input wire logic ref_clk_in,
	input wire logic spindle_on_in,
	input wire logic diag_clk_in,
	input wire logic diag_data_in,
	output logic motor_at_speed_out,
	output logic motor_stopped_out,
	output logic [7:0] shown_code_out = '0,
	output logic [7:0] bit_count_out = '0
);
	// Only one drive is modelled, so no two drives can share an address
	int unsigned spin = 0;
	// Speed ramps slowly toward the commanded state, so blinking phases last
	always @(posedge ref_clk_in) begin
		if (spindle_on_in && spin < SPIN_CYC) spin <= spin + 1;
		else if (!spindle_on_in && spin > 0) spin <= spin - 1;
	end
	assign motor_at_speed_out = spin == SPIN_CYC;
	assign motor_stopped_out = spin == 0;
	// Display shift register, fed on each rising port clock
	always @(posedge diag_clk_in) begin
		shown_code_out <= {shown_code_out[6:0], diag_data_in};
		bit_count_out <= bit_count_out + 8'h01;
	end
endmodule : dps_far_model

/* File: verification/dps_panel_tb_top.sv */
// Self-checking bench for the drive panel and startup self-test block
`timescale 1ns/1ps
module dps_panel_tb_top;
	import dps_pkg::*;
	logic ref_clk_in = '0, rst_n_in = '0, stop_button_in = '0, motor_seated_in = '0, dwell_timeout_in = '0;
	logic cmd_active_in = '0, cmd_start_in = '0, host_diag_req_in = '0, bus_sel_in = '0, rom_fail_in = '0;
	logic ram_fail_in = '0, buf_fail_in = '0, manual_reset_switch_in = '0, parity_option_switch_in = '0;
	logic diag_enable_switch_in = '0, retry_option_switch_in = '0, capacity_code_switch_in = '0;
	logic [6:0] ext_fail_in = '0;
	logic [7:0] bus_address_shunt_in = 8'h04, bus_data_in = '0, cmd_status_out, shown, nbits;
	logic motor_at_speed_in, motor_stopped_in, spindle_on_out, half_speed_out, latch_engage_out, ready_led_out;
	logic activity_led_out, self_test_done_out, select_resp_out, cmd_abort_out, parity_check_en_out, retries_en_out;
	logic startup_diag_en_out, repeat_diag_out, diag_clk_out, diag_data_out;
	logic [2:0] ext_test_step_out;
	logic [1:0] format_code_out;
	int err_total = 0;
	int tests_run = 0;
	// System clock, 20 ns period
	always #10 ref_clk_in = ~ref_clk_in;
	// Block with shortened counts, and its far side
	dps_panel #(.BASIC_CYC(50), .EXT_CYC(20), .BLINK_HALF_CYC(4), .RESUME_CYC(10)) DUT (.ref_clk_in, .rst_n_in,
		.stop_button_in, .motor_seated_in, .motor_at_speed_in, .motor_stopped_in, .dwell_timeout_in, .cmd_active_in,
		.cmd_start_in, .host_diag_req_in, .rom_fail_in, .ram_fail_in, .buf_fail_in, .ext_fail_in,
		.manual_reset_switch_in, .parity_option_switch_in, .diag_enable_switch_in, .retry_option_switch_in,
		.capacity_code_switch_in, .bus_address_shunt_in, .bus_data_in, .bus_sel_in, .spindle_on_out, .half_speed_out,
		.latch_engage_out, .ready_led_out, .activity_led_out, .self_test_done_out, .select_resp_out, .cmd_abort_out,
		.cmd_status_out, .ext_test_step_out, .parity_check_en_out, .retries_en_out, .startup_diag_en_out,
		.repeat_diag_out, .format_code_out, .diag_clk_out, .diag_data_out);
	dps_far_model far (.ref_clk_in, .spindle_on_in(spindle_on_out), .diag_clk_in(diag_clk_out),
		.diag_data_in(diag_data_out), .motor_at_speed_out(motor_at_speed_in), .motor_stopped_out(motor_stopped_in),
		.shown_code_out(shown), .bit_count_out(nbits));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : cyc
	// Reset for 12 cycles with the switch bank set
	task automatic boot(input logic [3:0] sw);
		cyc(1);
		rst_n_in = 1'b0;
		{capacity_code_switch_in, retry_option_switch_in, diag_enable_switch_in, parity_option_switch_in} = sw;
		cyc(12);
		rst_n_in = 1'b1;
	endtask : boot
	// Wait for one whole frame on the display
	task automatic code_is(input logic [7:0] exp);
		logic [7:0] n0;
		n0 = nbits;
		for (int i = 0; i < 600 && nbits != n0 + 8'h08; i++) cyc(1);
		chk("frame bits", n0 + 8'h08, nbits);
		chk("code", exp, shown);
	endtask : code_is
	// One command start; the abort pulse stands for the cycle after the start edge
	task automatic cmd(input logic ab);
		cmd_start_in = 1'b1;
		cyc(1);
		chk("abort", 8'(ab), 8'(cmd_abort_out));
		cmd_start_in = 1'b0;
		cyc(3);
	endtask : cmd
	// Each basic failure shows its code, the highest priority winning
	task automatic t_fail;
		logic [7:0] codes [3] = '{CODE_ROM, CODE_RAM, CODE_BUF};
		bus_sel_in = 1'b1;
		bus_data_in = 8'h04;
		for (int i = 0; i < 3; i++) begin
			{rom_fail_in, ram_fail_in, buf_fail_in} = 3'(3'b111 >> i);
			boot(4'h0);
			code_is(codes[i]);
			chk("blocked", 8'h00, 8'({select_resp_out, self_test_done_out}));
		end
		{rom_fail_in, ram_fail_in, buf_fail_in, bus_sel_in} = 4'h0;
	endtask : t_fail
	// All four retry/diagnostic codes; moves after latching are ignored
	task automatic t_opts;
		logic [3:0] sw;
		for (int i = 0; i < 4; i++) begin
			sw = {i[1], i[1], i[0], i[0]};
			boot(sw);
			cyc(10);
			{capacity_code_switch_in, retry_option_switch_in, diag_enable_switch_in, parity_option_switch_in} = ~sw;
			cyc(4);
			chk("opts", 8'({!sw[0], !sw[2] | sw[1], sw[1], sw[1] & sw[2], sw[3] ? FMT_10_5 : FMT_10_0}),
				8'({parity_check_en_out, retries_en_out, startup_diag_en_out, repeat_diag_out, format_code_out}));
		end
		// Manual reset switch on clears the latched options; normal runs keep it off
		manual_reset_switch_in = 1'b1;
		cyc(4);
		chk("held", 8'h00, 8'({parity_check_en_out, retries_en_out, startup_diag_en_out, repeat_diag_out,
			format_code_out}));
		manual_reset_switch_in = 1'b0;
	endtask : t_opts
	// Extended step 2 fails; the next command aborts, the one after is clean
	task automatic t_ext;
		ext_fail_in = 7'h04;
		boot(4'h2);
		code_is(EXT_CODE_BASE + 8'h02);
		for (int i = 0; i < 400 && self_test_done_out !== 1'b1; i++) cyc(1);
		chk("done", 8'h01, 8'(self_test_done_out));
		cmd(1'b1);
		chk("status", 8'(1 << STAT_EXEC_ERR_BIT), cmd_status_out);
		cmd(1'b0);
		chk("status", 8'h00, cmd_status_out);
		bus_sel_in = 1'b1;
		for (int k = 0; k < 2; k++) begin
			bus_data_in = k ? 8'hfb : 8'h04;
			cyc(2);
			chk("select", 8'(!k), 8'(select_resp_out));
		end
		{bus_sel_in, ext_fail_in} = 8'h00;
		// Host request reruns the extended tests from step 0; step 1 runs 20 to 39 cycles in
		host_diag_req_in = 1'b1;
		cyc(1);
		host_diag_req_in = 1'b0;
		cyc(29);
		chk("host diag", 8'h01, 8'({self_test_done_out, ext_test_step_out}));
	endtask : t_ext
	// Load, reach speed, dwell and resume, stop while a command runs
	task automatic t_spin;
		logic r0;
		motor_seated_in = 1'b1;
		cyc(5);
		chk("latch", 8'h01, 8'(latch_engage_out));
		// Blink phase toggles every four cycles, so two looks four apart differ
		r0 = ready_led_out;
		cyc(4);
		chk("spinup blink", 8'(!r0), 8'(ready_led_out));
		for (int i = 0; i < 100 && motor_at_speed_in !== 1'b1; i++) cyc(1);
		cyc(4);
		chk("ready", 8'h01, 8'(ready_led_out));
		dwell_timeout_in = 1'b1;
		cyc(4);
		dwell_timeout_in = 1'b0;
		cyc(2);
		chk("half", 8'h01, 8'(half_speed_out));
		cmd(1'b0);
		chk("full", 8'h00, 8'(half_speed_out));
		r0 = ready_led_out;
		cyc(4);
		chk("resume blink", 8'(!r0), 8'(ready_led_out));
		{cmd_active_in, stop_button_in} = 2'b11;
		cyc(20);
		chk("hold", 8'h03, 8'({spindle_on_out, activity_led_out}));
		cmd_active_in = 1'b0;
		cyc(4);
		chk("down", 8'h02, 8'({spindle_on_out, latch_engage_out, activity_led_out}));
		for (int i = 0; i < 100 && motor_stopped_in !== 1'b1; i++) cyc(1);
		cyc(4);
		chk("free", 8'h00, 8'({latch_engage_out, ready_led_out}));
		{motor_seated_in, stop_button_in} = 2'b00;
	endtask : t_spin
	task automatic close_out;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	// Main sequence
	initial begin
		t_fail();
		t_opts();
		t_ext();
		t_spin();
		close_out();
	end
	// Watchdog, well past the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		err_total++;
		close_out();
	end
endmodule : dps_panel_tb_top
bind dps_panel dps_panel_monitor mon (.ref_clk_in, .rst_n_in, .cmd_active_in, .cmd_start_in, .bus_address_shunt_in,
	.bus_data_in, .bus_sel_in, .spindle_on_out, .latch_engage_out, .ready_led_out, .select_resp_out, .cmd_abort_out,
	.cmd_status_out, .diag_clk_out, .diag_data_out);
